// ---- core/aim_regs.svh ----
// register map and field positions of the analog input block
// assumes modbus reference numbers are used directly as addresses
`ifndef AIM_REGS_SVH
`define AIM_REGS_SVH

// channel counts
`define AIM_NCH      8
`define AIM_NVAL     9
`define AIM_NCH16    16'h0008
`define AIM_NVAL16   16'h0009
`define AIM_NSTW16   16'h0010

// coil space (0x) reference numbers
`define AIM_CO_MAXRST 16'h0065
`define AIM_CO_MINRST 16'h006f
`define AIM_CO_OPEN   16'h0079
`define AIM_CO_HIAL   16'h0083
`define AIM_CO_LOAL   16'h008d

// holding register space (4x) reference numbers
`define AIM_RG_VAL    16'h9c41
`define AIM_RG_MAX    16'h9c4b
`define AIM_RG_MIN    16'h9c55
`define AIM_RG_STAT   16'h9ca5
`define AIM_RG_CODE   16'h9d09
`define AIM_RG_MASK   16'h9d1d
`define AIM_RG_FLAGS  16'h9d71

// status word bit positions
`define AIM_ST_TMO  0
`define AIM_ST_OVR  1
`define AIM_ST_UND  2
`define AIM_ST_OPEN 3
`define AIM_ST_ADC  7
`define AIM_ST_CAL  9

// reset values
`define AIM_MASK_RST  8'hff
`define AIM_CODE_RST  16'h0000
`define AIM_AVG_CODE  16'h0000
`define AIM_FLAGS_RST 16'h0000

`endif

// ---- core/aim_pkg.sv ----
// types shared by the analog input register block
// assumes aim_regs.svh for counts
`include "aim_regs.svh"

package aim_pkg;
   typedef logic [15:0] aim_word_t;

   // one register or coil access from the host side
   typedef struct packed {
      logic      write;
      logic      coil;
      aim_word_t addr;
      aim_word_t wdata;
   } aim_req_t;

   // answer to one access, data low bit for coils
   typedef struct packed {
      logic      err;
      aim_word_t data;
   } aim_rsp_t;

   // front end condition of one channel
   typedef struct packed {
      logic tmo;
      logic ovr;
      logic und;
      logic open;
      logic adc;
      logic cal;
   } aim_stat_t;
endpackage : aim_pkg

// ---- core/aim_chan_track.sv ----
// present value, extremes and alarms of one channel
// assumes thresholds held stable by the surrounding logic
`timescale 1ns/1ps
`default_nettype none

module aim_chan_track import aim_pkg::*; (
   input  wire logic      clk_sys,
   input  wire logic      rst,
   input  wire logic      upd,
   input  wire logic      clr_max,
   input  wire logic      clr_min,
   input  wire aim_word_t val_in,
   input  wire aim_word_t hi_lim,
   input  wire aim_word_t lo_lim,
   output var  aim_word_t val_reg,
   output var  aim_word_t max_reg,
   output var  aim_word_t min_reg,
   output var  logic      hi_reg,
   output var  logic      lo_reg
);
   logic      seen_reg;
   logic      seen_next;
   aim_word_t val_next;
   aim_word_t max_next;
   aim_word_t min_next;

   // a clear takes the value the channel holds after this edge
   always_comb begin
      seen_next = seen_reg | upd;
      val_next  = upd ? val_in : val_reg;
      max_next  = max_reg;
      min_next  = min_reg;
      if (clr_max || (upd && !seen_reg)) begin
         max_next = val_next; // [RQ1]
      end else if (upd && val_in > max_reg) begin
         max_next = val_in; // [RQ5]
      end
      if (clr_min || (upd && !seen_reg)) begin
         min_next = val_next; // [RQ2]
      end else if (upd && val_in < min_reg) begin
         min_next = val_in; // [RQ6]
      end
   end

   // value and extremes
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         seen_reg <= 1'b0;
         val_reg  <= 16'h0000;
         max_reg  <= 16'h0000;
         min_reg  <= 16'h0000;
      end else begin
         seen_reg <= seen_next;
         val_reg  <= val_next;
         max_reg  <= max_next;
         min_reg  <= min_next;
      end
   end

   // alarms follow the value that is shown, never a stale one
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         hi_reg <= 1'b0;
         lo_reg <= 1'b0;
      end else begin
         hi_reg <= seen_next && (val_next > hi_lim); // [RQ3]
         lo_reg <= seen_next && (val_next < lo_lim); // [RQ4]
      end
   end

   chk_max_reload: assert property (@(posedge clk_sys) disable iff (rst) // [RQ1]
      clr_max |=> max_reg == val_reg) else $error("max not reloaded");
   chk_min_reload: assert property (@(posedge clk_sys) disable iff (rst) // [RQ2]
      clr_min |=> min_reg == val_reg) else $error("min not reloaded");
   chk_hi_alarm: assert property (@(posedge clk_sys) disable iff (rst) // [RQ3]
      seen_reg |-> hi_reg == (val_reg > $past(hi_lim))) else $error("high alarm wrong");
   chk_lo_alarm: assert property (@(posedge clk_sys) disable iff (rst) // [RQ4]
      seen_reg |-> lo_reg == (val_reg < $past(lo_lim))) else $error("low alarm wrong");
   chk_max_bound: assert property (@(posedge clk_sys) disable iff (rst) // [RQ5]
      upd && !clr_max |=> max_reg >= val_reg && max_reg >= $past(max_reg)) else $error("max lost");
   // the first sample seeds the minimum upward from the reset zero, so the bound starts after it
   chk_min_bound: assert property (@(posedge clk_sys) disable iff (rst) // [RQ6]
      upd && seen_reg && !clr_min |=> min_reg <= val_reg && min_reg <= $past(min_reg)) else $error("min lost");
endmodule : aim_chan_track

`default_nettype wire

// ---- core/aim_avg.sv ----
// mean of the enabled channels of one sample set
// assumes samples arrive as one strobe for all channels
`timescale 1ns/1ps
`default_nettype none

module aim_avg import aim_pkg::*; (
   input  wire logic                          clk_sys,
   input  wire logic                          rst,
   input  wire logic                          smp_valid,
   input  wire logic [`AIM_NCH-1:0][15:0]     smp_value,
   input  wire logic [`AIM_NCH-1:0]           en_mask,
   output var  aim_word_t                     avg_reg,
   output var  logic                          vld_reg
);
   logic [18:0] sum;
   logic [18:0] cnt;

   // disabled channels stay out of both sum and count
   always_comb begin
      sum = 19'h00000;
      cnt = 19'h00000;
      for (int i = 0; i < `AIM_NCH; i++) begin
         if (en_mask[i]) begin
            sum = sum + {3'h0, smp_value[i]}; // [RQ11]
            cnt = cnt + 19'h00001;
         end
      end
   end

   // divider is wide but the block is not timing critical
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         avg_reg <= 16'h0000;
         vld_reg <= 1'b0;
      end else begin
         vld_reg <= smp_valid && (cnt != 19'h00000);
         if (smp_valid && cnt != 19'h00000) begin
            avg_reg <= 16'(sum / cnt);
         end
      end
   end
endmodule : aim_avg

`default_nettype wire

// ---- core/aim_top.sv ----
// register and coil map of the eight channel analog input block
// assumes the host side decodes frames into single accesses
//
// Notes on behaviour
// (RQ1) Writing a max-reset coil of a channel or the average loads its maximum with its present value.
// (RQ2) Writing a min-reset coil of a channel or the average loads its minimum with its present value.
// (RQ3) A channel's high alarm flag is 1 while its value is above its upper limit, the average has its own.
// (RQ4) From its first sample on, a channel's low alarm flag is 1 while its value is below its lower limit, the average has its own.
// (RQ5) The highest value since reset is readable for each channel and the average.
// (RQ6) The lowest value since reset is readable for each channel and the average.
// (RQ7) Each channel's status takes two consecutive words, channel n at the base plus two n.
// (RQ8) Status bits are timeout 0, over range 1, under range 2, open 3, converter 7, calibration 9.
// (RQ9) Sixteen logic rule engine flags sit in one readable and writable word.
// (RQ10) A readable open circuit flag per enabled channel is set while that input is disconnected; a disabled channel reads 0.
// (RQ11) The enable word masks channels out of conversion and out of the average.
`timescale 1ns/1ps
`default_nettype none

module aim_top import aim_pkg::*; (
   input  wire logic                         clk_sys,
   input  wire logic                         rst,
   input  wire logic                         req_valid,
   input  wire aim_req_t                     req,
   output var  logic                         rsp_valid,
   output var  aim_rsp_t                     rsp,
   input  wire logic                         smp_valid,
   input  wire logic [`AIM_NCH-1:0][15:0]    smp_value,
   input  wire aim_stat_t [`AIM_NCH-1:0]     chan_stat,
   input  wire logic [`AIM_NVAL-1:0][15:0]   hi_lim,
   input  wire logic [`AIM_NVAL-1:0][15:0]   lo_lim,
   output var  logic [`AIM_NCH-1:0]          en_reg,
   output var  logic [`AIM_NCH-1:0][15:0]    code_reg,
   output var  aim_word_t                    flags_reg
);
   aim_stat_t [`AIM_NCH-1:0]   stat_reg;
   logic [`AIM_NVAL-1:0]       upd_w;
   aim_word_t                  vin_w   [`AIM_NVAL];
   aim_word_t                  val_w   [`AIM_NVAL];
   aim_word_t                  max_w   [`AIM_NVAL];
   aim_word_t                  min_w   [`AIM_NVAL];
   logic [`AIM_NVAL-1:0]       hi_w;
   logic [`AIM_NVAL-1:0]       lo_w;
   logic [`AIM_NVAL-1:0]       clr_max;
   logic [`AIM_NVAL-1:0]       clr_min;
   aim_word_t                  avg_val;
   logic                       avg_vld;
   aim_rsp_t                   rsp_next;
   logic                       wr_code;
   logic                       wr_mask;
   logic                       wr_flags;
   aim_word_t                  o_mx;
   aim_word_t                  o_mn;
   aim_word_t                  o_op;
   aim_word_t                  o_hi;
   aim_word_t                  o_lo;
   aim_word_t                  o_val;
   aim_word_t                  o_max;
   aim_word_t                  o_min;
   aim_word_t                  o_st;
   aim_word_t                  o_cd;
   logic                       rd;
   logic                       wr;

   // offsets of the access from each table base
   assign o_mx  = req.addr - `AIM_CO_MAXRST;
   assign o_mn  = req.addr - `AIM_CO_MINRST;
   assign o_op  = req.addr - `AIM_CO_OPEN;
   assign o_hi  = req.addr - `AIM_CO_HIAL;
   assign o_lo  = req.addr - `AIM_CO_LOAL;
   assign o_val = req.addr - `AIM_RG_VAL;
   assign o_max = req.addr - `AIM_RG_MAX;
   assign o_min = req.addr - `AIM_RG_MIN;
   assign o_st  = req.addr - `AIM_RG_STAT;
   assign o_cd  = req.addr - `AIM_RG_CODE;
   assign rd    = req_valid && !req.write;
   assign wr    = req_valid && req.write;

   // averaging of the enabled channels
   aim_avg u_avg (
      .clk_sys   (clk_sys),
      .rst       (rst),
      .smp_valid (smp_valid),
      .smp_value (smp_value),
      .en_mask   (en_reg),
      .avg_reg   (avg_val),
      .vld_reg   (avg_vld)
   );

   // eight inputs plus the average, each with its own tracker
   genvar g;
   for (g = 0; g < `AIM_NVAL; g++) begin : g_ch
      if (g < `AIM_NCH) begin : g_in
         assign upd_w[g] = smp_valid & en_reg[g]; // [RQ11]
         assign vin_w[g] = smp_value[g];
         // disabled channels report no condition
         always_ff @(posedge clk_sys or posedge rst) begin
            if (rst) begin
               stat_reg[g] <= '0;
            end else begin
               stat_reg[g] <= en_reg[g] ? chan_stat[g] : '0; // [RQ10]
            end
         end
      end else begin : g_av
         assign upd_w[g] = avg_vld;
         assign vin_w[g] = avg_val;
      end
      aim_chan_track u_trk (
         .clk_sys (clk_sys),
         .rst     (rst),
         .upd     (upd_w[g]),
         .clr_max (clr_max[g]),
         .clr_min (clr_min[g]),
         .val_in  (vin_w[g]),
         .hi_lim  (hi_lim[g]),
         .lo_lim  (lo_lim[g]),
         .val_reg (val_w[g]),
         .max_reg (max_w[g]),
         .min_reg (min_w[g]),
         .hi_reg  (hi_w[g]),
         .lo_reg  (lo_w[g])
      );
   end

   // status word of one channel
   function automatic aim_word_t stat_word(input aim_stat_t s);
      aim_word_t w;
      w = 16'h0000;
      w[`AIM_ST_TMO]  = s.tmo; // [RQ8]
      w[`AIM_ST_OVR]  = s.ovr;
      w[`AIM_ST_UND]  = s.und;
      w[`AIM_ST_OPEN] = s.open;
      w[`AIM_ST_ADC]  = s.adc;
      w[`AIM_ST_CAL]  = s.cal;
      return w;
   endfunction : stat_word

   // write decode: coil writes become one-cycle clear pulses
   always_comb begin
      clr_max  = '0;
      clr_min  = '0;
      wr_code  = 1'b0;
      wr_mask  = 1'b0;
      wr_flags = 1'b0;
      if (wr && req.coil && o_mx < `AIM_NVAL16) begin
         clr_max[o_mx[3:0]] = 1'b1; // [RQ1]
      end
      if (wr && req.coil && o_mn < `AIM_NVAL16) begin
         clr_min[o_mn[3:0]] = 1'b1; // [RQ2]
      end
      if (wr && !req.coil) begin
         wr_code  = o_cd < `AIM_NCH16;
         wr_mask  = req.addr == `AIM_RG_MASK;
         wr_flags = req.addr == `AIM_RG_FLAGS;
      end
   end

   // answer: read data, or error for unmapped or read-only targets
   always_comb begin
      rsp_next = '{err: 1'b1, data: 16'h0000};
      if (wr) begin
         rsp_next.err = !(wr_code || wr_mask || wr_flags || (|clr_max) || (|clr_min));
      end else if (rd && req.coil) begin
         if (o_op < `AIM_NCH16) begin
            rsp_next = '{err: 1'b0, data: {15'h0000, stat_reg[o_op[2:0]].open}}; // [RQ10]
         end else if (o_hi < `AIM_NVAL16) begin
            rsp_next = '{err: 1'b0, data: {15'h0000, hi_w[o_hi[3:0]]}}; // [RQ3]
         end else if (o_lo < `AIM_NVAL16) begin
            rsp_next = '{err: 1'b0, data: {15'h0000, lo_w[o_lo[3:0]]}}; // [RQ4]
         end
      end else if (rd) begin
         if (o_val < `AIM_NVAL16) begin
            rsp_next = '{err: 1'b0, data: val_w[o_val[3:0]]};
         end else if (o_max < `AIM_NVAL16) begin
            rsp_next = '{err: 1'b0, data: max_w[o_max[3:0]]}; // [RQ5]
         end else if (o_min < `AIM_NVAL16) begin
            rsp_next = '{err: 1'b0, data: min_w[o_min[3:0]]}; // [RQ6]
         end else if (o_st < `AIM_NSTW16) begin
            // second word of each pair carries no flags yet
            rsp_next.err  = 1'b0;
            rsp_next.data = o_st[0] ? 16'h0000 : stat_word(stat_reg[o_st[3:1]]); // [RQ7]
         end else if (o_cd < `AIM_NCH16) begin
            rsp_next = '{err: 1'b0, data: code_reg[o_cd[2:0]]};
         end else if (o_cd == `AIM_NCH16) begin
            rsp_next = '{err: 1'b0, data: `AIM_AVG_CODE};
         end else if (req.addr == `AIM_RG_MASK) begin
            rsp_next = '{err: 1'b0, data: {8'h00, en_reg}};
         end else if (req.addr == `AIM_RG_FLAGS) begin
            rsp_next = '{err: 1'b0, data: flags_reg}; // [RQ9]
         end
      end
   end

   // answer registers, one cycle after the access
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         rsp_valid <= 1'b0;
         rsp       <= '0;
      end else begin
         rsp_valid <= req_valid;
         if (req_valid) begin
            rsp <= rsp_next;
         end
      end
   end

   // configuration written by the host
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         en_reg    <= `AIM_MASK_RST;
         code_reg  <= {`AIM_NCH{`AIM_CODE_RST}};
         flags_reg <= `AIM_FLAGS_RST;
      end else begin
         if (wr_code) begin
            code_reg[o_cd[2:0]] <= req.wdata;
         end
         if (wr_mask) begin
            en_reg <= req.wdata[`AIM_NCH-1:0]; // [RQ11]
         end
         if (wr_flags) begin
            flags_reg <= req.wdata; // [RQ9]
         end
      end
   end

   // status and configuration
   chk_stat_word: assert property (@(posedge clk_sys) disable iff (rst) // [RQ8]
      rd && !req.coil && req.addr == `AIM_RG_STAT
      |=> rsp.data[`AIM_ST_OPEN] == $past(stat_reg[0].open) && rsp.data[`AIM_ST_CAL] == $past(stat_reg[0].cal)
         && rsp.data[`AIM_ST_TMO] == $past(stat_reg[0].tmo))
      else $error("status word bits wrong");
   chk_stat_pair: assert property (@(posedge clk_sys) disable iff (rst) // [RQ7]
      rd && !req.coil && req.addr == `AIM_RG_STAT + `AIM_NSTW16 |=> rsp_valid && rsp.err)
      else $error("status past last pair answered");

   // the host leaves one idle cycle between accesses; no write may fall in it
   chk_flags_rw: assert property (@(posedge clk_sys) disable iff (rst) // [RQ9]
      wr && !req.coil && req.addr == `AIM_RG_FLAGS ##1 !wr ##1 rd && !req.coil && req.addr == `AIM_RG_FLAGS
      |=> rsp.data == $past(req.wdata, 3) && !rsp.err)
      else $error("flags word not read back");
   chk_open_flag: assert property (@(posedge clk_sys) disable iff (rst) // [RQ10]
      en_reg[0] ##1 rd && req.coil && req.addr == `AIM_CO_OPEN |=> rsp.data[0] == $past(chan_stat[0].open, 2))
      else $error("open flag wrong");

   // channel 6 is left off by a partial mask while its front end reports faults
   chk_mask_hold: assert property (@(posedge clk_sys) disable iff (rst) // [RQ11]
      !en_reg[6] |=> $stable(val_w[6]) && !stat_reg[6].open)
      else $error("disabled channel changed");

   // main scenarios
   cov_max_clear: cover property (@(posedge clk_sys) disable iff (rst) clr_max[`AIM_NCH]);
   cov_stat_read: cover property (@(posedge clk_sys) disable iff (rst)
      rd && !req.coil && o_st < `AIM_NSTW16 ##1 rsp.data != 16'h0000);
   cov_avg_alarm: cover property (@(posedge clk_sys) disable iff (rst) avg_vld ##1 hi_w[`AIM_NCH]);
   cov_min_clear: cover property (@(posedge clk_sys) disable iff (rst) clr_min[`AIM_NCH]);
   cov_part_mask: cover property (@(posedge clk_sys) disable iff (rst) smp_valid && en_reg != `AIM_MASK_RST);

   // answers seen by the host
   chk_val_read: assert property (@(posedge clk_sys) disable iff (rst) // [RQ11]
      rd && !req.coil && req.addr == `AIM_RG_VAL + `AIM_NCH16 |=> !rsp.err && rsp.data == $past(val_w[`AIM_NCH]))
      else $error("average value word wrong");

   chk_max_read: assert property (@(posedge clk_sys) disable iff (rst) // [RQ5]
      rd && !req.coil && req.addr == `AIM_RG_MAX |=> !rsp.err && rsp.data == $past(max_w[0]))
      else $error("max word wrong");

   chk_min_read: assert property (@(posedge clk_sys) disable iff (rst) // [RQ6]
      rd && !req.coil && req.addr == `AIM_RG_MIN |=> !rsp.err && rsp.data == $past(min_w[0]))
      else $error("min word wrong");

   chk_stat_second: assert property (@(posedge clk_sys) disable iff (rst) // [RQ7]
      rd && !req.coil && o_st < `AIM_NSTW16 && o_st[0] |=> !rsp.err && rsp.data == 16'h0000)
      else $error("second status word not zero");

   chk_hi_read: assert property (@(posedge clk_sys) disable iff (rst) // [RQ3]
      rd && req.coil && req.addr == `AIM_CO_HIAL + `AIM_NCH16 |=> !rsp.err && rsp.data[0] == $past(hi_w[`AIM_NCH]))
      else $error("average high alarm read wrong");

   chk_lo_read: assert property (@(posedge clk_sys) disable iff (rst) // [RQ4]
      rd && req.coil && req.addr == `AIM_CO_LOAL + `AIM_NCH16 |=> !rsp.err && rsp.data[0] == $past(lo_w[`AIM_NCH]))
      else $error("average low alarm read wrong");

   chk_ro_refused: assert property (@(posedge clk_sys) disable iff (rst) // [RQ5]
      wr && !req.coil && (o_val < `AIM_NVAL16 || o_max < `AIM_NVAL16 || o_min < `AIM_NVAL16)
      |=> rsp.err && rsp.data == 16'h0000)
      else $error("read-only word accepted a write");

   // writes, clears and configuration
   chk_avg_max_clr: assert property (@(posedge clk_sys) disable iff (rst) // [RQ1]
      wr && req.coil && req.addr == `AIM_CO_MAXRST + `AIM_NCH16 |=> !rsp.err && max_w[`AIM_NCH] == val_w[`AIM_NCH])
      else $error("average max not reloaded");

   chk_avg_min_clr: assert property (@(posedge clk_sys) disable iff (rst) // [RQ2]
      wr && req.coil && req.addr == `AIM_CO_MINRST + `AIM_NCH16 |=> !rsp.err && min_w[`AIM_NCH] == val_w[`AIM_NCH])
      else $error("average min not reloaded");

   chk_mask_write: assert property (@(posedge clk_sys) disable iff (rst) // [RQ11]
      wr && !req.coil && req.addr == `AIM_RG_MASK |=> !rsp.err && en_reg == $past(req.wdata[`AIM_NCH-1:0]))
      else $error("enable mask not written");

   chk_flags_hold: assert property (@(posedge clk_sys) disable iff (rst) // [RQ9]
      !(wr && !req.coil && req.addr == `AIM_RG_FLAGS) |=> $stable(flags_reg))
      else $error("flags word changed without a write");
endmodule : aim_top

`default_nettype wire

// ---- sim/aim_host.sv ----
// host side model: issues single register and coil accesses to the block
// assumes one access at a time and one answer pulse per access
`timescale 1ns/1ps
`default_nettype none

module aim_host import aim_pkg::*; (
   input  wire logic     clk_sys,
   output var  logic     req_valid,
   output var  aim_req_t req,
   input  wire logic     rsp_valid,
   input  wire aim_rsp_t rsp
);
   // idle bus at time zero
   initial begin
      req_valid = 1'b0;
      req       = '0;
   end

   // request held up to the taking edge, answer awaited for a few edges only
   task automatic access(input logic wr, input logic cl, input aim_word_t a, input aim_word_t d,
                         output aim_rsp_t r);
      int n;
      @(posedge clk_sys);
      #1;
      req_valid = 1'b1;
      req       = '{wr, cl, a, d};
      @(posedge clk_sys);
      #1;
      req_valid = 1'b0;
      req       = '{~wr, ~cl, ~a, ~d}; // stale fields never repeat the last access
      n = 0;
      while (rsp_valid !== 1'b1 && n < 2) begin
         @(posedge clk_sys);
         #1;
         n++;
      end
      r = (rsp_valid === 1'b1) ? rsp : 'x; // a missing answer fails every compare
   endtask : access
endmodule : aim_host

`default_nettype wire

// ---- sim/tb_aim_top.sv ----
// self-checking bench of the analog input register and coil map
// assumes aim_host is the only requester and samples come from this bench
`timescale 1ns/1ps
`default_nettype none
`include "aim_regs.svh"

module tb_aim_top;
   import aim_pkg::*;

   logic                       clk_sys, rst, req_valid, rsp_valid, smp_valid;
   aim_req_t                   req;
   aim_rsp_t                   rsp;
   logic [`AIM_NCH-1:0][15:0]  smp_value;
   aim_stat_t [`AIM_NCH-1:0]   chan_stat;
   logic [`AIM_NVAL-1:0][15:0] hi_lim, lo_lim;
   logic [`AIM_NCH-1:0]        en_reg, mask;
   logic [`AIM_NCH-1:0][15:0]  code_reg;
   aim_word_t                  flags_reg;
   aim_word_t                  cur [9], mx [9], mn [9];
   logic [8:0]                 seeded;
   int                         n_mismatch, num_checks;

   aim_top aim_top_i (.clk_sys(clk_sys), .rst(rst), .req_valid(req_valid), .req(req),
      .rsp_valid(rsp_valid), .rsp(rsp), .smp_valid(smp_valid), .smp_value(smp_value),
      .chan_stat(chan_stat), .hi_lim(hi_lim), .lo_lim(lo_lim), .en_reg(en_reg),
      .code_reg(code_reg), .flags_reg(flags_reg));

   aim_host aim_host_i (.clk_sys(clk_sys), .req_valid(req_valid), .req(req),
      .rsp_valid(rsp_valid), .rsp(rsp));

   // 100 MHz system clock
   initial begin
      clk_sys = 1'b0;
      forever #5 clk_sys = ~clk_sys;
   end

   task automatic print_verdict();
      $display("checks %0d mismatches %0d", num_checks, n_mismatch);
      if (n_mismatch == 0 && num_checks > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask : print_verdict

   task automatic chk(input string what, input aim_word_t exp, input aim_word_t got);
      num_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask : chk

   // one access; refused ones must answer data 0, write data is not compared
   task automatic acc(input string what, input logic wr, input logic cl, input int a,
                      input aim_word_t d, input logic err, input aim_word_t exp);
      aim_rsp_t r;
      aim_host_i.access(wr, cl, 16'(a), d, r);
      chk({what, " err"}, {15'h0, err}, {15'h0, r.err});
      if (!wr || err) chk(what, err ? 16'h0000 : exp, r.data);
   endtask : acc

   // bench copy of value and extremes, first sample seeds the extremes
   task automatic upd(input int i, input aim_word_t v);
      cur[i] = v;
      mx[i]  = (!seeded[i] || v > mx[i]) ? v : mx[i];
      mn[i]  = (!seeded[i] || v < mn[i]) ? v : mn[i];
      seeded[i] = 1'b1;
   endtask : upd

   task automatic sample(input logic [7:0][15:0] v);
      int s, c;
      s = 0;
      c = 0;
      @(posedge clk_sys);
      #1;
      smp_value = v;
      smp_valid = 1'b1;
      @(posedge clk_sys);
      #1;
      smp_valid = 1'b0;
      smp_value = ~v;
      for (int i = 0; i < 8; i++) begin
         if (mask[i]) begin
            upd(i, v[i]);
            s += v[i];
            c++;
         end
      end
      if (c != 0) upd(8, 16'(s / c)); // floor of the enabled mean
      repeat (3) @(posedge clk_sys);
   endtask : sample

   task automatic check_all();
      for (int i = 0; i < 9; i++) begin
         acc("value", 0, 0, `AIM_RG_VAL + i, 0, 0, cur[i]);
         acc("max", 0, 0, `AIM_RG_MAX + i, 0, 0, mx[i]);
         acc("min", 0, 0, `AIM_RG_MIN + i, 0, 0, mn[i]);
         acc("high alarm", 0, 1, `AIM_CO_HIAL + i, 0, 0, {15'h0, cur[i] > hi_lim[i]});
         acc("low alarm", 0, 1, `AIM_CO_LOAL + i, 0, 0, {15'h0, cur[i] < lo_lim[i]});
      end
   endtask : check_all

   // reset values, flag word, refused accesses
   task automatic t_access();
      acc("mask rst", 0, 0, `AIM_RG_MASK, 0, 0, 16'h00ff);
      acc("flags rst", 0, 0, `AIM_RG_FLAGS, 0, 0, 16'h0000);
      acc("flags wr", 1, 0, `AIM_RG_FLAGS, 16'ha5c3, 0, 0);
      acc("flags rd", 0, 0, `AIM_RG_FLAGS, 0, 0, 16'ha5c3);
      chk("flags port", 16'ha5c3, flags_reg);
      acc("value ro", 1, 0, `AIM_RG_VAL, 16'h1234, 1, 0);
      acc("max coil rd", 0, 1, `AIM_CO_MAXRST, 0, 1, 0);
      acc("unmapped", 0, 0, `AIM_RG_VAL - 1, 0, 1, 0);
      acc("code wr", 1, 0, `AIM_RG_CODE + 3, 16'h0143, 0, 0);
      acc("code rd", 0, 0, `AIM_RG_CODE + 3, 0, 0, 16'h0143);
      chk("code port", 16'h0143, code_reg[3]);
      acc("avg code wr", 1, 0, `AIM_RG_CODE + 8, 16'h0143, 1, 0);
   endtask : t_access

   // rising and falling samples exercise extremes and both alarms
   task automatic t_track();
      sample({16'h1700, 16'h1600, 16'h1500, 16'h1400, 16'h1300, 16'h1200, 16'h1100, 16'h1000});
      check_all();
      sample({16'h0807, 16'h2006, 16'h0805, 16'h2004, 16'h0803, 16'h2002, 16'h0801, 16'h2000});
      check_all();
   endtask : t_track

   // clear coils load the present value, written value ignored
   task automatic t_clear();
      sample({16'h1207, 16'h1206, 16'h1205, 16'h1204, 16'h1203, 16'h1202, 16'h1201, 16'h1200});
      for (int i = 0; i < 9; i++) begin
         acc("max clear", 1, 1, `AIM_CO_MAXRST + i, 0, 0, 0);
         acc("min clear", 1, 1, `AIM_CO_MINRST + i, 16'h0001, 0, 0);
         mx[i] = cur[i];
         mn[i] = cur[i];
      end
      check_all();
   endtask : t_clear

   // one status bit per channel, channel 6 all bits, channel 7 none
   task automatic t_status();
      logic [5:0] p;
      for (int n = 0; n < 8; n++) chan_stat[n] = aim_stat_t'((n < 6) ? 6'h20 >> n : {6{n == 6}});
      repeat (3) @(posedge clk_sys);
      for (int n = 0; n < 8; n++) begin
         p = chan_stat[n];
         acc("status lo", 0, 0, `AIM_RG_STAT + 2 * n, 0, 0, {6'h0, p[0], 1'b0, p[1], 3'h0, p[2], p[3], p[4], p[5]});
         acc("status hi", 0, 0, `AIM_RG_STAT + 2 * n + 1, 0, 0, 16'h0000);
         acc("open", 0, 1, `AIM_CO_OPEN + n, 0, 0, {15'h0, p[2]});
      end
      acc("status end", 0, 0, `AIM_RG_STAT + 2 * 8, 0, 1, 0);
   endtask : t_status

   // masked channels freeze, mean taken over enabled ones only
   task automatic t_mask();
      acc("mask wr", 1, 0, `AIM_RG_MASK, 16'h000f, 0, 0);
      acc("mask rd", 0, 0, `AIM_RG_MASK, 0, 0, 16'h000f);
      chk("enable port", 16'h000f, {8'h0, en_reg});
      mask = 8'h0f;
      sample({16'h0515, 16'h0512, 16'h050f, 16'h050c, 16'h0509, 16'h0506, 16'h0503, 16'h0500});
      check_all();
      acc("masked status", 0, 0, `AIM_RG_STAT + 12, 0, 0, 16'h0000);
   endtask : t_mask

   // hang guard, far beyond the roughly five hundred cycles the tests need
   initial begin
      #200us;
      n_mismatch++;
      $display("Error watchdog expected done seen hang");
      print_verdict();
   end

   initial begin
      rst = 1'b1;
      smp_valid = 1'b0;
      smp_value = '0;
      chan_stat = '0;
      hi_lim = {9{16'h1800}};
      lo_lim = {9{16'h0c00}};
      hi_lim[8] = 16'h1400;
      lo_lim[8] = 16'h1390;
      mask = 8'hff;
      seeded = '0;
      repeat (6) @(posedge clk_sys);
      #1;
      rst = 1'b0;
      chk("enable rst", 16'h00ff, {8'h0, en_reg});
      t_access();
      t_track();
      t_clear();
      t_status();
      t_mask();
      print_verdict();
   end
endmodule : tb_aim_top

`default_nettype wire
